/* File: core/pstc_port_bank.v */
// one port's counter memory with field-wise increment and wrap detect
`timescale 1ns/1ns
`include "pstc_defs.vh"
module pstc_port_bank
#(
    parameter LEN_W = `PSTC_LEN_W
)
(
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // count events
    input wire [`PSTC_NUM_CTR-1:0] ev,
    input wire [LEN_W-1:0] tx_len,
    input wire [LEN_W-1:0] rx_len,
    // read port
    input wire [3:0] rd_word,
    output wire [31:0] rd_data,
    // one-cycle wrap pulses
    output reg [`PSTC_NUM_CTR-1:0] wrap
);

reg [31:0] mem_ff [0:`PSTC_NUM_WORDS-1];
reg [31:0] nxt_mem [0:`PSTC_NUM_WORDS-1];

assign rd_data = mem_ff[rd_word];

// ----------------------------------------
// counter placement: word address and size code
// ----------------------------------------
function [6:0] place;
    input integer i;
    begin
        case (i)
            0: place = {4'h0, `PSTC_SZ_D};
            1: place = {4'h1, `PSTC_SZ_L};
            2: place = {4'h1, `PSTC_SZ_U};
            3: place = {4'h2, `PSTC_SZ_LL};
            4: place = {4'h2, `PSTC_SZ_LU};
            5: place = {4'h3, `PSTC_SZ_D};
            6: place = {4'h4, `PSTC_SZ_D};
            7: place = {4'h5, `PSTC_SZ_D};
            8: place = {4'h6, `PSTC_SZ_L};
            9: place = {4'h6, `PSTC_SZ_U};
            10: place = {4'h7, `PSTC_SZ_LL};
            11: place = {4'h7, `PSTC_SZ_LU};
            12: place = {4'h8, `PSTC_SZ_L};
            13: place = {4'h8, `PSTC_SZ_U};
            14: place = {4'h9, `PSTC_SZ_L};
            15: place = {4'h9, `PSTC_SZ_U};
            16: place = {4'hA, `PSTC_SZ_LL};
            17: place = {4'hA, `PSTC_SZ_LU};
            18: place = {4'hB, `PSTC_SZ_LL};
            19: place = {4'hB, `PSTC_SZ_LU};
            20: place = {4'hC, `PSTC_SZ_LL};
            21: place = {4'hC, `PSTC_SZ_M};
            22: place = {4'hC, `PSTC_SZ_U};
            23: place = {4'hD, `PSTC_SZ_LL};
            24: place = {4'hD, `PSTC_SZ_LU};
            25: place = {4'hE, `PSTC_SZ_LL};
            26: place = {4'hE, `PSTC_SZ_LU};
            27: place = {4'hF, `PSTC_SZ_LL};
            28: place = {4'hF, `PSTC_SZ_M};
            default: place = {4'hF, `PSTC_SZ_U};
        endcase
    end
endfunction

// ----------------------------------------
// field mask and shift for a size code
// ----------------------------------------
function [32:0] fmask;
    input [2:0] sz;
    begin
        case (sz)
            `PSTC_SZ_D: fmask = 33'h0_FFFF_FFFF;
            `PSTC_SZ_L: fmask = 33'h0_00FF_FFFF;
            `PSTC_SZ_U: fmask = 33'h0_FF00_0000;
            `PSTC_SZ_M: fmask = 33'h0_00FF_0000;
            `PSTC_SZ_LL: fmask = 33'h0_0000_FFFF;
            default: fmask = 33'h0_FFFF_0000;
        endcase
    end
endfunction

function [4:0] fshift;
    input [2:0] sz;
    begin
        case (sz)
            `PSTC_SZ_U: fshift = 5'd24;
            `PSTC_SZ_M: fshift = 5'd16;
            `PSTC_SZ_LU: fshift = 5'd16;
            default: fshift = 5'd0;
        endcase
    end
endfunction

// ----------------------------------------
// update: several fields of one word may count in the same cycle
// ----------------------------------------
integer w;
integer c;
reg [6:0] pl;
reg [32:0] fm;
reg [32:0] msk;
reg [32:0] fld;
reg [32:0] amt;
reg [32:0] sum;
always @*
begin
    pl = 7'h00;
    fm = 33'h0;
    msk = 33'h0;
    fld = 33'h0;
    amt = 33'h0;
    sum = 33'h0;
    wrap = {`PSTC_NUM_CTR{1'b0}};
    for (w = 0; w < `PSTC_NUM_WORDS; w = w + 1)
        nxt_mem[w] = mem_ff[w];
    for (c = 0; c < `PSTC_NUM_CTR; c = c + 1)
    begin
        pl = place(c);
        fm = fmask(pl[2:0]);
        msk = fm >> fshift(pl[2:0]);
        fld = ({1'b0, nxt_mem[pl[6:3]]} >> fshift(pl[2:0])) & msk;
        if (c == `PSTC_BIT_TX_BYTES)
            amt = {{(33-LEN_W){1'b0}}, tx_len};
        else if (c == `PSTC_BIT_RX_BYTES || c == `PSTC_BIT_RX_TOTAL_BYTES)
            amt = {{(33-LEN_W){1'b0}}, rx_len};
        else
            amt = 33'h1;
        sum = fld + amt;
        if (ev[c])
        begin
            wrap[c] = (sum > msk);
            sum = (sum & msk) << fshift(pl[2:0]);
            nxt_mem[pl[6:3]] = (nxt_mem[pl[6:3]] & ~fm[31:0]) | sum[31:0];
        end
    end
end

genvar g;
generate
    for (g = 0; g < `PSTC_NUM_WORDS; g = g + 1)
    begin : g_word
        always @(posedge clk_sys)
        begin
            if (sys_rst)
                mem_ff[g] <= 32'h0000_0000;
            else
                mem_ff[g] <= nxt_mem[g];
        end
    end
endgenerate

endmodule

/* File: core/pstc_top.v */
// statistics counters for all ports with wishbone access and wrap reporting
`timescale 1ns/1ns
`include "pstc_defs.vh"
module pstc_top
#(
    parameter NUM_PORTS = `PSTC_NUM_PORTS,
    parameter LEN_W = `PSTC_LEN_W
)
(
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // mac events, 30 per port; bits 27 and 28 of each port are not used
    input wire [NUM_PORTS*`PSTC_NUM_CTR-1:0] mac_ev,
    input wire [NUM_PORTS*LEN_W-1:0] mac_tx_len,
    input wire [NUM_PORTS*LEN_W-1:0] mac_rx_len,
    // queue manager and buffer manager events
    input wire [NUM_PORTS-1:0] qm_filter_ev,
    input wire [NUM_PORTS-1:0] bm_delay_ev,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`PSTC_ADR_W-1:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // cpu interrupt
    output reg wrap_irq
);

// ----------------------------------------
// control registers
// ----------------------------------------
reg [31:0] ctrl_ff;
reg [`PSTC_PORT_SEL_W-1:0] port_sel_ff;
wire count_en;

assign count_en = ctrl_ff[`PSTC_CTRL_EN_BIT];

// ----------------------------------------
// bus decode
// ----------------------------------------
wire bus_req;
wire bus_wr;
wire bus_rd;
wire hit_ctr;
wire [3:0] ctr_word;

// only the edge that raises ack takes the access, so side effects happen once
assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign bus_wr = bus_req & wb_we_i;
assign bus_rd = bus_req & ~wb_we_i;
assign hit_ctr = (wb_adr_i >= `PSTC_REG_CTR_BASE) && (wb_adr_i <= `PSTC_REG_CTR_LAST);
assign ctr_word = wb_adr_i[5:2];

// ----------------------------------------
// per-port banks and sticky wrap flags
// ----------------------------------------
wire [NUM_PORTS*32-1:0] bank_rd;
wire [NUM_PORTS*`PSTC_NUM_CTR-1:0] bank_wrap;
reg [NUM_PORTS*`PSTC_NUM_CTR-1:0] flags_ff;
wire [NUM_PORTS-1:0] deliver;

genvar p;
generate
    for (p = 0; p < NUM_PORTS; p = p + 1)
    begin : g_port
        wire [`PSTC_NUM_CTR-1:0] ev_all;
        wire [`PSTC_NUM_CTR-1:0] mac_sl;

        assign mac_sl = mac_ev[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR];

        // filtering from the queue manager, delay discard from the buffer manager
        assign ev_all = {mac_sl[29],
                         bm_delay_ev[p],
                         qm_filter_ev[p],
                         mac_sl[26:0]} & {`PSTC_NUM_CTR{count_en}};

        // the wrap word of a port counts as delivered when its low half is read
        assign deliver[p] = bus_rd && (wb_adr_i == `PSTC_REG_WRAP_LO)
                            && (port_sel_ff == p);

        // one full bank for each port
        pstc_port_bank #(
            .LEN_W(LEN_W)
        ) u_bank (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .ev(ev_all),
            .tx_len(mac_tx_len[p*LEN_W +: LEN_W]),
            .rx_len(mac_rx_len[p*LEN_W +: LEN_W]),
            .rd_word(ctr_word),
            .rd_data(bank_rd[p*32 +: 32]),
            .wrap(bank_wrap[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR])
        );

        // a wrap in the delivering cycle survives: set wins over clear
        always @(posedge clk_sys)
        begin
            if (sys_rst)
                flags_ff[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR] <= {`PSTC_NUM_CTR{1'b0}};
            else if (deliver[p])
                flags_ff[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR] <=
                    bank_wrap[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR];
            else
                flags_ff[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR] <=
                    flags_ff[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR]
                    | bank_wrap[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR];
        end
    end
endgenerate

// ----------------------------------------
// wrap word of the selected port
// ----------------------------------------
wire [29:0] sel_flags;
wire [63:0] wrap_word;
wire [NUM_PORTS-1:0] port_pend;

assign sel_flags = flags_ff[port_sel_ff*`PSTC_NUM_CTR +: `PSTC_NUM_CTR];

generate
    for (p = 0; p < NUM_PORTS; p = p + 1)
    begin : g_pend
        assign port_pend[p] = |flags_ff[p*`PSTC_NUM_CTR +: `PSTC_NUM_CTR];
    end
endgenerate

// other status: counting enable, selected port, pending ports
assign wrap_word = {16'h0000,
                    {(8-NUM_PORTS){1'b0}}, port_pend,
                    {(8-`PSTC_PORT_SEL_W){1'b0}}, port_sel_ff,
                    1'b0, count_en,
                    sel_flags};

// ----------------------------------------
// read mux
// ----------------------------------------
reg [31:0] rd_val;
always @*
begin
    if (wb_adr_i == `PSTC_REG_CTRL)
        rd_val = ctrl_ff;
    else if (wb_adr_i == `PSTC_REG_PORT_SEL)
        rd_val = {{(32-`PSTC_PORT_SEL_W){1'b0}}, port_sel_ff};
    else if (wb_adr_i == `PSTC_REG_WRAP_LO)
        rd_val = wrap_word[31:0];
    else if (wb_adr_i == `PSTC_REG_WRAP_HI)
        rd_val = wrap_word[63:32];
    else if (hit_ctr)
        rd_val = bank_rd[port_sel_ff*32 +: 32];
    else
        rd_val = 32'h0000_0000;
end

// ----------------------------------------
// bus answer and register writes
// ----------------------------------------
always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        ctrl_ff <= `PSTC_CTRL_RST;
        port_sel_ff <= {`PSTC_PORT_SEL_W{1'b0}};
    end
    else
    begin
        wb_ack_o <= bus_req;
        if (bus_rd)
            wb_dat_o <= rd_val;
        if (bus_wr && wb_sel_i[0])
        begin
            if (wb_adr_i == `PSTC_REG_CTRL)
                ctrl_ff <= {31'h0000_0000, wb_dat_i[`PSTC_CTRL_EN_BIT]};
            else if (wb_adr_i == `PSTC_REG_PORT_SEL)
                port_sel_ff <= wb_dat_i[`PSTC_PORT_SEL_W-1:0];
        end
    end
end

// ----------------------------------------
// interrupt: any held wrap flag on any port
// ----------------------------------------
always @(posedge clk_sys)
begin
    if (sys_rst)
        wrap_irq <= 1'b0;
    else
        wrap_irq <= |(flags_ff | bank_wrap);
end

endmodule

/* File: pkg/pstc_defs.vh */
// constants for the per-port statistics counter block
// Function
// - each ethernet port has its own full set of counters
// - every counter wraps to zero past its maximum, never saturates
// - any counter wrap raises an interrupt toward the cpu
// - mac feeds all events but two: queue manager filtering, buffer manager delay discard
// - 64-bit wrap word: bits 29:0 wrap flags, 63:30 other status
// - bits 0-4: tx bytes, unicast, send fail, flow control, non-unicast
// - bits 5-11: rx bytes, rx frames, total bytes/frames, flow ctl, mcast, bcast
// - length bins at bits 12,14,16,17,18,19
// - error and discard flags at bits 13,15,20 to 29
// - counter located by word address plus size code
// - full word uses 31:0; 24-bit 23:0 shares word with 8-bit 31:24
// - 16-bit low 15:0, high 31:16; mid 8-bit counter 23:16
// - all counters readable by the cpu over its interface
`ifndef PSTC_DEFS_VH
`define PSTC_DEFS_VH

// ----------------------------------------
// sizes
// ----------------------------------------
`define PSTC_NUM_PORTS 4
`define PSTC_NUM_CTR 30
`define PSTC_NUM_WORDS 16
`define PSTC_LEN_W 11

// ----------------------------------------
// size codes
// ----------------------------------------
`define PSTC_SZ_D 3'h0
`define PSTC_SZ_L 3'h1
`define PSTC_SZ_U 3'h2
`define PSTC_SZ_M 3'h3
`define PSTC_SZ_LL 3'h4
`define PSTC_SZ_LU 3'h5

// ----------------------------------------
// counters fed by byte lengths, and the filter and delay counter bits
// ----------------------------------------
`define PSTC_BIT_TX_BYTES 0
`define PSTC_BIT_RX_BYTES 5
`define PSTC_BIT_RX_TOTAL_BYTES 7
`define PSTC_BIT_FILTER 27
`define PSTC_BIT_DELAY 28

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PSTC_ADR_W 8
`define PSTC_REG_CTRL 8'h00
`define PSTC_REG_PORT_SEL 8'h04
`define PSTC_REG_WRAP_LO 8'h08
`define PSTC_REG_WRAP_HI 8'h0C
`define PSTC_REG_CTR_BASE 8'h40
`define PSTC_REG_CTR_LAST 8'h7C

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define PSTC_CTRL_RST 32'h0000_0001
`define PSTC_CTRL_EN_BIT 0
`define PSTC_PORT_SEL_W 2

`endif

/* File: tb/pstc_host.sv */
// wishbone host model standing in for the cpu
`timescale 1ns/1ns
module pstc_host
(
    // clock
    input wire clk_sys,
    // wishbone master side
    output logic cyc = 1'b0,
    output logic stb = 1'b0,
    output logic we = 1'b0,
    output logic [7:0] adr = 8'h00,
    output logic [31:0] dat_w = 32'h0,
    output logic [3:0] sel = 4'h0,
    input wire logic [31:0] dat_r,
    input wire logic ack
);
    // one classic cycle; the request stands until ack is sampled high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        begin
            @(posedge clk_sys);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat_w <= d;
            sel <= 4'hF;
            @(posedge clk_sys);
            while (ack !== 1'b1)
                @(posedge clk_sys);
            q = dat_r;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
endmodule

/* File: tb/pstc_monitor.sv */
// concurrent checks on the statistics block ports
`timescale 1ns/1ns
`include "pstc_defs.vh"
module pstc_monitor
#(
    parameter NUM_PORTS = 4
)
(
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // events
    input wire [NUM_PORTS*`PSTC_NUM_CTR-1:0] mac_ev,
    input wire [NUM_PORTS-1:0] qm_filter_ev,
    input wire [NUM_PORTS-1:0] bm_delay_ev,
    // wishbone and interrupt
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`PSTC_ADR_W-1:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wrap_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_lo = req && !wb_we_i && wb_adr_i == `PSTC_REG_WRAP_LO;
    wire rd_hi = req && !wb_we_i && wb_adr_i == `PSTC_REG_WRAP_HI;
    wire rd_gap = req && !wb_we_i && wb_adr_i >= 8'h10 && wb_adr_i < 8'h40;
    wire any_ev = (|mac_ev) || (|qm_filter_ev) || (|bm_delay_ev);

    chk_ack_follows: assert property (req |=> wb_ack_o)
        else $error("request not acked next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_no_stray_ack: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    chk_gap_reads_zero: assert property (rd_gap |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_lo_top_zero: assert property (rd_lo |=> wb_dat_o[31] == 1'b0)
        else $error("wrap low word bit31 set");
    chk_hi_upper_zero: assert property (rd_hi |=> wb_dat_o[31:16] == 16'h0)
        else $error("wrap high word upper bits set");
    chk_irq_cause: assert property ($rose(wrap_irq) |-> $past(any_ev))
        else $error("interrupt without event");
    chk_irq_held: assert property (wrap_irq && !rd_lo && !$past(rd_lo) |=> wrap_irq)
        else $error("interrupt dropped before delivery");
endmodule
bind pstc_top pstc_monitor #(.NUM_PORTS(NUM_PORTS)) pstc_monitor_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .mac_ev(mac_ev), .qm_filter_ev(qm_filter_ev), .bm_delay_ev(bm_delay_ev),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wrap_irq(wrap_irq));

/* File: tb/pstc_top_tb.sv */
// register-level tests of the statistics counter block
`timescale 1ns/1ns
`include "pstc_defs.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module pstc_top_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [119:0] mac_ev = '0;
    logic [43:0] tx_len = '0;
    logic [43:0] rx_len = '0;
    logic [3:0] qm_ev = '0;
    logic [3:0] bm_ev = '0;
    logic cyc, stb, we, ack, wrap_irq;
    logic [7:0] adr;
    logic [31:0] dat_w, dat_r, q;
    logic [3:0] sel;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    // one event on every counter of port 1: a one in each field, byte fields take the lengths
    logic [31:0] exp1 [16] = '{32'h0000_05EE, 32'h0100_0001, 32'h0001_0001, 32'h0000_0040,
        32'h1, 32'h0000_0040,
        32'h0100_0001, 32'h0001_0001, 32'h0100_0001, 32'h0100_0001, 32'h0001_0001,
        32'h0001_0001, 32'h0101_0001, 32'h0001_0001, 32'h0001_0001, 32'h0101_0001};

    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    pstc_top #(.NUM_PORTS(4), .LEN_W(11)) pstc_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .mac_ev(mac_ev), .mac_tx_len(tx_len), .mac_rx_len(rx_len), .qm_filter_ev(qm_ev),
        .bm_delay_ev(bm_ev), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat_w), .wb_sel_i(sel), .wb_dat_o(dat_r), .wb_ack_o(ack), .wrap_irq(wrap_irq));
    pstc_host pstc_host_i (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .dat_w(dat_w), .sel(sel), .dat_r(dat_r), .ack(ack));

    task final_report;
        begin
            $display("compares=%0d errors=%0d", compares, errors);
            if (errors == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        pstc_host_i.xfer(1'b1, a, d, q);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        begin
            pstc_host_i.xfer(1'b0, a, 32'h0, q);
            `CHK(q, e)
        end
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            errors++;
            final_report;
        end
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(`PSTC_REG_CTRL, 32'h1);
        rchk(`PSTC_REG_WRAP_LO, 32'h4000_0000);
        rchk(8'h20, 32'h0);
        wr(`PSTC_REG_PORT_SEL, 32'h1);
        @(posedge clk_sys);
        mac_ev[30 +: 30] <= {30{1'b1}};
        qm_ev[1] <= 1'b1;
        bm_ev[1] <= 1'b1;
        tx_len[11 +: 11] <= 11'h5EE;
        rx_len[11 +: 11] <= 11'h040;
        @(posedge clk_sys);
        mac_ev <= '0;
        qm_ev <= '0;
        bm_ev <= '0;
        for (int i = 0; i < 16; i++)
            rchk(`PSTC_REG_CTR_BASE + 8'(4 * i), exp1[i]);
        wr(`PSTC_REG_PORT_SEL, 32'h0);
        rchk(`PSTC_REG_CTR_BASE, 32'h0);
        wr(`PSTC_REG_PORT_SEL, 32'h1);
        // 255 more events take three 8-bit fields from 1 past their top
        mac_ev[32] <= 1'b1;
        mac_ev[51] <= 1'b1;
        bm_ev[1] <= 1'b1;
        repeat (255) @(posedge clk_sys);
        mac_ev <= '0;
        bm_ev <= '0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        `CHK(wrap_irq, 1'b1)
        rchk(`PSTC_REG_WRAP_HI, 32'h0000_0201);
        rchk(`PSTC_REG_CTR_BASE + 8'h04, 32'h0000_0001);
        rchk(`PSTC_REG_CTR_BASE + 8'h30, 32'h0100_0001);
        rchk(`PSTC_REG_CTR_BASE + 8'h3C, 32'h0100_0001);
        rchk(`PSTC_REG_WRAP_LO, 32'h5020_0004);
        rchk(`PSTC_REG_WRAP_LO, 32'h4000_0000);
        @(posedge clk_sys);
        `CHK(wrap_irq, 1'b0)
        // counting off: an event must leave its field alone
        wr(`PSTC_REG_CTRL, 32'h0);
        rchk(`PSTC_REG_CTRL, 32'h0);
        mac_ev[31] <= 1'b1;
        @(posedge clk_sys);
        mac_ev <= '0;
        rchk(`PSTC_REG_CTR_BASE + 8'h04, 32'h0000_0001);
        wr(`PSTC_REG_CTRL, 32'h1);
        // a second reset clears counters and port select, and returns ctrl to its reset value of 1
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rchk(`PSTC_REG_PORT_SEL, 32'h0);
        rchk(`PSTC_REG_CTRL, 32'h1);
        wr(`PSTC_REG_PORT_SEL, 32'h1);
        rchk(`PSTC_REG_CTR_BASE + 8'h04, 32'h0);
        rchk(`PSTC_REG_WRAP_HI, 32'h0000_0001);
        final_report;
    end
endmodule
